// ### rs485_direction_and_address_control.sv
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RL1 - without auto direction, rts_n follows modem bit, or flow-control circuit when enabled
// RL2 - auto-direction bit hands rts_n to the transmitter, overriding both other sources
// RL3 - auto mode: rts_n low on transmit write, high after last bit leaves
// RL4 - software disables hardware flow control before using auto direction
// RL5 - inversion bit in auto mode: rts_n high while pending, low after done
// RL6 - multidrop bit selects 9-bit mode; ninth bit one marks address character
// RL7 - software sets multidrop, no special detect, forced-zero parity format
// RL8 - normal multidrop, receiver disabled: drop data characters until an address arrives
// RL9 - normal multidrop: address char flags parity error, is stored, raises line interrupt
// RL10 - host enables receiver only when the address equals its own station
// RL11 - enabled receiver keeps accepting; later address character flags parity error again
// RL12 - special detect on: incoming address characters compared with stored address
// RL13 - auto detect, receiver disabled: data and mismatched addresses are discarded
// RL14 - matching address enables receiver, is stored with parity flag, raises interrupt
// RL15 - auto detect, enabled: mismatched address disables receiver and is ignored
// RL16 - host-writable receiver enable, readable, also set and cleared by hardware
module rs485_direction_and_address_control (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_fifo_wr,
    input wire logic tx_all_empty,
    input wire logic flow_rts_n,
    output logic rts_n,
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    input wire logic rx_ninth,
    input wire logic rx_perr_in,
    output logic rx_push,
    output logic [7:0] rx_push_data,
    output logic rx_push_perr,
    output logic irq
);
    import rs485_pkg::*;

    typedef struct packed {
        logic [7:0] modem_control_reg;
        logic [7:0] line_format_reg;
        logic [7:0] interrupt_enable_reg;
        logic [7:0] extra_feature_control_reg;
        logic [7:0] enhanced_feature_reg;
        logic [7:0] second_soft_flow_off_char;
        logic rx_enable;
        logic [7:0] int_status;
        logic last_perr;
        logic tx_pending;
        logic rts_n;
        logic rx_push;
        logic [7:0] rx_push_data;
        logic rx_push_perr;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_s;

    state_s state_r;
    state_s state_nxt;

    function automatic logic known_addr(input logic [7:0] a);
        case (a)
            OFF_MODEM_CTRL, OFF_LINE_FORMAT, OFF_INT_ENABLE, OFF_EXTRA_FEAT,
            OFF_ENH_FEAT, OFF_SOFT_OFF2, OFF_RX_CTRL, OFF_INT_STATUS,
            OFF_INT_CLEAR, OFF_LINE_STATUS: known_addr = 1'b1;
            default: known_addr = 1'b0;
        endcase
    endfunction

    logic auto_dir;
    logic dir_inv;
    logic hw_flow;
    logic multidrop;
    logic special_det;
    logic addr_match;
    logic wr_access;
    logic [7:0] events;

    assign auto_dir = state_r.extra_feature_control_reg[XFEAT_AUTO_DIR_BIT];
    assign dir_inv = state_r.extra_feature_control_reg[XFEAT_DIR_INV_BIT];
    assign hw_flow = state_r.enhanced_feature_reg[ENH_HW_RTS_BIT];
    assign multidrop = state_r.extra_feature_control_reg[XFEAT_MULTIDROP_BIT];
    assign special_det = state_r.enhanced_feature_reg[ENH_SPECIAL_CHAR_BIT];
    assign addr_match = (rx_char == state_r.second_soft_flow_off_char); // [RL12]
    assign wr_access = psel && penable && state_r.pready && pwrite;

    always_comb begin
        state_nxt = state_r;
        events = 8'h00;
        state_nxt.rx_push = 1'b0;
        state_nxt.pready = 1'b0;
        state_nxt.pslverr = 1'b0;

        // apb: setup cycle prepares the answer, access cycle completes it
        if (psel && !penable) begin
            state_nxt.pready = 1'b1;
            state_nxt.pslverr = !known_addr(paddr);
            state_nxt.prdata = RDATA_ZERO;
            if (!pwrite) begin
                case (paddr)
                    OFF_MODEM_CTRL: state_nxt.prdata[7:0] = state_r.modem_control_reg;
                    OFF_LINE_FORMAT: state_nxt.prdata[7:0] = state_r.line_format_reg;
                    OFF_INT_ENABLE: state_nxt.prdata[7:0] = state_r.interrupt_enable_reg;
                    OFF_EXTRA_FEAT: state_nxt.prdata[7:0] = state_r.extra_feature_control_reg;
                    OFF_ENH_FEAT: state_nxt.prdata[7:0] = state_r.enhanced_feature_reg;
                    OFF_SOFT_OFF2: state_nxt.prdata[7:0] = state_r.second_soft_flow_off_char;
                    OFF_RX_CTRL: state_nxt.prdata[RXC_ENABLE_BIT] = state_r.rx_enable; // [RL16]
                    OFF_INT_STATUS: state_nxt.prdata[7:0] = state_r.int_status;
                    OFF_LINE_STATUS: begin
                        state_nxt.prdata[LSTAT_RTS_N_BIT] = state_r.rts_n;
                        state_nxt.prdata[LSTAT_TX_PEND_BIT] = state_r.tx_pending;
                        state_nxt.prdata[LSTAT_PARITY_ERR_BIT] = state_r.last_perr;
                    end
                    default: state_nxt.prdata = RDATA_ZERO;
                endcase
            end
        end

        if (wr_access) begin
            case (paddr)
                OFF_MODEM_CTRL: state_nxt.modem_control_reg = pwdata[7:0];
                OFF_LINE_FORMAT: state_nxt.line_format_reg = pwdata[7:0];
                OFF_INT_ENABLE: state_nxt.interrupt_enable_reg = pwdata[7:0];
                OFF_EXTRA_FEAT: state_nxt.extra_feature_control_reg = pwdata[7:0];
                OFF_ENH_FEAT: state_nxt.enhanced_feature_reg = pwdata[7:0];
                OFF_SOFT_OFF2: state_nxt.second_soft_flow_off_char = pwdata[7:0];
                OFF_RX_CTRL: state_nxt.rx_enable = pwdata[RXC_ENABLE_BIT]; // [RL16]
                OFF_INT_CLEAR: state_nxt.int_status = state_r.int_status & ~pwdata[7:0];
                default: state_nxt.rx_push = 1'b0;
            endcase
        end

        // transmit direction: pending from first fifo write until line fully idle
        if (tx_fifo_wr) begin
            state_nxt.tx_pending = 1'b1; // [RL3]
        end else if (state_r.tx_pending && tx_all_empty) begin
            state_nxt.tx_pending = 1'b0; // [RL3]
            events[IRQ_TX_DONE_BIT] = 1'b1;
        end

        if (auto_dir) begin
            // transmitter owns the pin, other sources ignored [RL2]
            state_nxt.rts_n = dir_inv ? state_nxt.tx_pending : !state_nxt.tx_pending; // [RL3] [RL5]
        end else if (hw_flow) begin
            state_nxt.rts_n = flow_rts_n; // [RL1]
        end else begin
            state_nxt.rts_n = !state_r.modem_control_reg[MODEM_RTS_BIT]; // [RL1]
        end

        // receive path
        if (rx_valid) begin
            if (!multidrop) begin
                state_nxt.rx_push = 1'b1;
                state_nxt.rx_push_perr = rx_perr_in;
            end else if (!special_det) begin
                if (rx_ninth) begin
                    // address char stored with parity error, enabled or not [RL6] [RL9] [RL11]
                    state_nxt.rx_push = 1'b1;
                    state_nxt.rx_push_perr = 1'b1;
                    events[IRQ_LINE_STAT_BIT] = 1'b1;
                end else begin
                    state_nxt.rx_push = state_r.rx_enable; // [RL8] [RL16]
                    state_nxt.rx_push_perr = 1'b0;
                end
            end else begin
                if (rx_ninth && addr_match) begin
                    state_nxt.rx_enable = 1'b1; // [RL14]
                    state_nxt.rx_push = 1'b1;
                    state_nxt.rx_push_perr = 1'b1; // [RL14]
                    events[IRQ_LINE_STAT_BIT] = 1'b1;
                end else if (rx_ninth) begin
                    state_nxt.rx_enable = 1'b0; // [RL15]
                end else begin
                    state_nxt.rx_push = state_r.rx_enable; // [RL13]
                    state_nxt.rx_push_perr = 1'b0;
                end
            end
            if (state_nxt.rx_push) begin
                state_nxt.rx_push_data = rx_char;
                state_nxt.last_perr = state_nxt.rx_push_perr;
            end
        end

        // sticky status: a new event wins over a clear in the same cycle
        state_nxt.int_status = state_nxt.int_status | events;
        state_nxt.irq = |(state_nxt.int_status & state_nxt.interrupt_enable_reg); // [RL9] [RL14]
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r.modem_control_reg <= RST_REG8;
            state_r.line_format_reg <= RST_REG8;
            state_r.interrupt_enable_reg <= RST_REG8;
            state_r.extra_feature_control_reg <= RST_REG8;
            state_r.enhanced_feature_reg <= RST_REG8;
            state_r.second_soft_flow_off_char <= RST_REG8;
            state_r.rx_enable <= RST_RX_ENABLE;
            state_r.int_status <= RST_REG8;
            state_r.last_perr <= 1'b0;
            state_r.tx_pending <= 1'b0;
            state_r.rts_n <= RST_RTS_N;
            state_r.rx_push <= 1'b0;
            state_r.rx_push_data <= RST_REG8;
            state_r.rx_push_perr <= 1'b0;
            state_r.irq <= 1'b0;
            state_r.pready <= 1'b0;
            state_r.pslverr <= 1'b0;
            state_r.prdata <= RDATA_ZERO;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign prdata = state_r.prdata;
    assign pready = state_r.pready;
    assign pslverr = state_r.pslverr;
    assign rts_n = state_r.rts_n;
    assign rx_push = state_r.rx_push;
    assign rx_push_data = state_r.rx_push_data;
    assign rx_push_perr = state_r.rx_push_perr;
    assign irq = state_r.irq;

    // checks
    logic normal_md;
    logic auto_md;
    assign normal_md = multidrop && !special_det;
    assign auto_md = multidrop && special_det;

    property p_rts_modem;
        @(posedge sys_clk) disable iff (!arst_n)
        (!auto_dir && !hw_flow) |=> (rts_n == !$past(state_r.modem_control_reg[MODEM_RTS_BIT]));
    endproperty
    a_rts_modem: assert property (p_rts_modem) else $error("rts_n not following modem bit"); // [RL1]

    property p_rts_flow;
        @(posedge sys_clk) disable iff (!arst_n)
        (!auto_dir && hw_flow) |=> (rts_n == $past(flow_rts_n));
    endproperty
    a_rts_flow: assert property (p_rts_flow) else $error("rts_n not following flow circuit"); // [RL1]

    property p_rts_auto_on;
        @(posedge sys_clk) disable iff (!arst_n)
        (auto_dir && !dir_inv && tx_fifo_wr) |=> !rts_n ##0 state_r.tx_pending;
    endproperty
    a_rts_auto_on: assert property (p_rts_auto_on) else $error("rts_n not low after tx write"); // [RL3]

    property p_rts_auto_off;
        @(posedge sys_clk) disable iff (!arst_n)
        (auto_dir && !dir_inv && state_r.tx_pending && tx_all_empty && !tx_fifo_wr)
            |=> rts_n && !state_r.tx_pending;
    endproperty
    a_rts_auto_off: assert property (p_rts_auto_off) else $error("rts_n not high after tx done"); // [RL3]

    property p_rts_inv;
        @(posedge sys_clk) disable iff (!arst_n)
        (auto_dir && dir_inv && tx_fifo_wr) |=> rts_n;
    endproperty
    a_rts_inv: assert property (p_rts_inv) else $error("inverted rts_n not high on tx write"); // [RL5]

    property p_drop_data;
        @(posedge sys_clk) disable iff (!arst_n)
        (normal_md && rx_valid && !rx_ninth && !state_r.rx_enable) |=> !rx_push;
    endproperty
    a_drop_data: assert property (p_drop_data) else $error("data stored while disabled"); // [RL8]

    property p_addr_flag;
        @(posedge sys_clk) disable iff (!arst_n)
        (normal_md && rx_valid && rx_ninth) |=> rx_push && rx_push_perr
            && rx_push_data == $past(rx_char);
    endproperty
    a_addr_flag: assert property (p_addr_flag) else $error("address char not flagged"); // [RL9]

    property p_addr_irq;
        @(posedge sys_clk) disable iff (!arst_n)
        (normal_md && rx_valid && rx_ninth && state_r.interrupt_enable_reg[IRQ_LINE_STAT_BIT]
            && !(wr_access && paddr == OFF_INT_ENABLE)) |=> irq;
    endproperty
    a_addr_irq: assert property (p_addr_irq) else $error("no line status interrupt"); // [RL9]

    property p_auto_mismatch;
        @(posedge sys_clk) disable iff (!arst_n)
        (auto_md && rx_valid && rx_ninth && !addr_match) |=> !rx_push && !state_r.rx_enable;
    endproperty
    a_auto_mismatch: assert property (p_auto_mismatch) else $error("mismatch not dropped"); // [RL15]

    property p_auto_data_drop;
        @(posedge sys_clk) disable iff (!arst_n)
        (auto_md && rx_valid && !rx_ninth && !state_r.rx_enable) |=> !rx_push;
    endproperty
    a_auto_data_drop: assert property (p_auto_data_drop) else $error("data kept while off"); // [RL13]

    property p_auto_match;
        @(posedge sys_clk) disable iff (!arst_n)
        (auto_md && rx_valid && rx_ninth && addr_match)
            |=> rx_push && rx_push_perr && state_r.rx_enable;
    endproperty
    a_auto_match: assert property (p_auto_match) else $error("match not stored"); // [RL14]

    property p_auto_override;
        @(posedge sys_clk) disable iff (!arst_n)
        auto_dir |=> ((rts_n ^ state_r.tx_pending) == !$past(dir_inv));
    endproperty
    a_auto_override: assert property (p_auto_override) else $error("tx owns rts_n"); // [RL2]

    property p_plain_push;
        @(posedge sys_clk) disable iff (!arst_n)
        (!multidrop && rx_valid) |=> rx_push && rx_push_perr == $past(rx_perr_in)
            && rx_push_data == $past(rx_char);
    endproperty
    a_plain_push: assert property (p_plain_push) else $error("plain char not pushed"); // [RL6]

    property p_enabled_data;
        @(posedge sys_clk) disable iff (!arst_n)
        (normal_md && rx_valid && !rx_ninth && state_r.rx_enable) |=> rx_push && !rx_push_perr;
    endproperty
    a_enabled_data: assert property (p_enabled_data) else $error("enabled data dropped"); // [RL11]

    // normal multidrop leaves the receiver enable to the host alone
    property p_md_hold_en;
        @(posedge sys_clk) disable iff (!arst_n)
        (normal_md && !(wr_access && paddr == OFF_RX_CTRL))
            |=> state_r.rx_enable == $past(state_r.rx_enable);
    endproperty
    a_md_hold_en: assert property (p_md_hold_en) else $error("enable moved"); // [RL16]

    c_auto_dir: cover property (@(posedge sys_clk) disable iff (!arst_n)
        auto_dir && tx_fifo_wr ##[1:50] !state_r.tx_pending);
    c_normal_addr: cover property (@(posedge sys_clk) disable iff (!arst_n)
        normal_md && rx_valid && rx_ninth);
    c_auto_match: cover property (@(posedge sys_clk) disable iff (!arst_n)
        auto_md && rx_valid && rx_ninth && addr_match);
    c_irq: cover property (@(posedge sys_clk) disable iff (!arst_n) irq);
    c_auto_disable: cover property (@(posedge sys_clk) disable iff (!arst_n)
        auto_md && rx_valid && rx_ninth && !addr_match && state_r.rx_enable);

endmodule // rs485_direction_and_address_control
`default_nettype wire

// ### rs485_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module rs485_line_model #(
    parameter int FRAME = 40
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic tx_fifo_wr,
    output logic tx_all_empty,
    output logic rx_valid,
    output logic [7:0] rx_char,
    output logic rx_ninth,
    output logic rx_perr_in
);
    int cnt;
    // one frame per character; empty rises once the stop bit is out
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            tx_all_empty <= 1'b1;
        end else if (tx_fifo_wr) begin
            cnt <= FRAME;
            tx_all_empty <= 1'b0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else begin
            cnt <= 0;
            tx_all_empty <= 1'b1;
        end
    end
    initial begin
        rx_valid = 1'b0;
        rx_char = 8'hFF;
        rx_ninth = 1'b1;
        rx_perr_in = 1'b1;
    end
    // lines outside a character show the inverse of the last one
    task send(input logic [7:0] c, input logic n, input logic p);
        rx_valid <= 1'b1;
        rx_char <= c;
        rx_ninth <= n;
        rx_perr_in <= p;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_char <= ~c;
        rx_ninth <= ~n;
        rx_perr_in <= ~p;
    endtask
endmodule // rs485_line_model
`default_nettype wire

// ### rs485_pkg.sv
package rs485_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_MODEM_CTRL = 8'h00;
    localparam logic [7:0] OFF_LINE_FORMAT = 8'h04;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h08;
    localparam logic [7:0] OFF_EXTRA_FEAT = 8'h0C;
    localparam logic [7:0] OFF_ENH_FEAT = 8'h10;
    localparam logic [7:0] OFF_SOFT_OFF2 = 8'h14;
    localparam logic [7:0] OFF_RX_CTRL = 8'h18;
    localparam logic [7:0] OFF_INT_STATUS = 8'h1C;
    localparam logic [7:0] OFF_INT_CLEAR = 8'h20;
    localparam logic [7:0] OFF_LINE_STATUS = 8'h24;

    // field positions
    localparam int MODEM_RTS_BIT = 1;
    localparam int XFEAT_MULTIDROP_BIT = 0;
    localparam int XFEAT_AUTO_DIR_BIT = 4;
    localparam int XFEAT_DIR_INV_BIT = 5;
    localparam int ENH_SPECIAL_CHAR_BIT = 5;
    localparam int ENH_HW_RTS_BIT = 6;
    localparam int IRQ_TX_DONE_BIT = 1;
    localparam int IRQ_LINE_STAT_BIT = 2;
    localparam int RXC_ENABLE_BIT = 0;
    localparam int LSTAT_RTS_N_BIT = 0;
    localparam int LSTAT_TX_PEND_BIT = 1;
    localparam int LSTAT_PARITY_ERR_BIT = 2;

    // reset values
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic RST_RX_ENABLE = 1'b0;
    localparam logic RST_RTS_N = 1'b1;

    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage

// ### tb_rs485_direction_and_address_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rs485_direction_and_address_control;
    import rs485_pkg::*;
    logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic tx_fifo_wr = 0, flow_rts_n = 1, e, last_p;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, rts_n, rx_push, rx_push_perr, irq;
    logic tx_all_empty, rx_valid, rx_ninth, rx_perr_in;
    logic [7:0] rx_char, rx_push_data, last_d;
    int miscompares = 0, n_compared = 0, n_push = 0, k;
    initial forever #2 sys_clk = ~sys_clk;
    rs485_direction_and_address_control rs485_direction_and_address_control_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_fifo_wr(tx_fifo_wr),
        .tx_all_empty(tx_all_empty), .flow_rts_n(flow_rts_n), .rts_n(rts_n),
        .rx_valid(rx_valid), .rx_char(rx_char), .rx_ninth(rx_ninth),
        .rx_perr_in(rx_perr_in), .rx_push(rx_push), .rx_push_data(rx_push_data),
        .rx_push_perr(rx_push_perr), .irq(irq));
    rs485_line_model #(.FRAME(40)) rs485_line_model_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .tx_fifo_wr(tx_fifo_wr),
        .tx_all_empty(tx_all_empty), .rx_valid(rx_valid), .rx_char(rx_char),
        .rx_ninth(rx_ninth), .rx_perr_in(rx_perr_in));
    always @(posedge sys_clk) begin
        if (rx_push === 1'b1) begin
            n_push++;
            last_d = rx_push_data;
            last_p = rx_push_perr;
        end
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task summarize;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) chk("pready wait", 0, 1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, q, x);
    endtask
    task rxc(input logic [7:0] c, input logic n, p, x, ep);
        int b;
        b = n_push;
        rs485_line_model_inst.send(c, n, p);
        tick(3);
        chk("push count", n_push - b, {31'b0, x});
        if (x) begin
            chk("rx data", last_d, c);
            chk("rx perr", last_p, ep);
        end
    endtask
    task tx_and_wait(input logic idle);
        tx_fifo_wr <= 1'b1;
        tick(1);
        tx_fifo_wr <= 1'b0;
        tick(2);
        chk("rts pending", rts_n, !idle);
        for (k = 0; k < 100 && rts_n !== idle; k++) tick(1);
        chk("rts done", rts_n, idle);
        chk("frame time", k >= 36, 1);
    endtask
    initial begin
        #40000;
        miscompares++;
        summarize;
    end
    initial begin
        tick(10);
        arst_n <= 1'b1;
        tick(1);
        chk("rts reset", rts_n, 1);
        rd("modem reset", OFF_MODEM_CTRL, 0);
        rd("rx ctrl reset", OFF_RX_CTRL, 0);
        rd("line status reset", OFF_LINE_STATUS, 32'h0000_0001);
        apb(1'b0, 8'hFC, 0);
        chk("unmapped err", e, 1);
        chk("unmapped data", q, 0);
        wr(OFF_MODEM_CTRL, 32'h0000_0002);
        tick(2);
        chk("rts modem", rts_n, 0);
        wr(OFF_ENH_FEAT, 32'h0000_0040);
        tick(2);
        chk("rts flow high", rts_n, 1);
        flow_rts_n <= 1'b0;
        tick(2);
        chk("rts flow low", rts_n, 0);
        wr(OFF_EXTRA_FEAT, 32'h0000_0010);
        tick(2);
        chk("rts auto idle", rts_n, 1);
        wr(OFF_INT_ENABLE, 32'h0000_0006);
        wr(OFF_ENH_FEAT, 32'h0000_0000);
        tx_and_wait(1'b1);
        tick(2);
        chk("irq tx done", irq, 1);
        rd("status tx", OFF_INT_STATUS, 32'h0000_0002);
        wr(OFF_INT_CLEAR, 32'h0000_0002);
        tick(2);
        chk("irq cleared", irq, 0);
        wr(OFF_EXTRA_FEAT, 32'h0000_0030);
        tick(2);
        chk("rts inv idle", rts_n, 0);
        tx_and_wait(1'b0);
        wr(OFF_INT_CLEAR, 32'h0000_0002);
        wr(OFF_EXTRA_FEAT, 32'h0000_0000);
        rxc(8'hA5, 1, 1, 1, 1);
        wr(OFF_EXTRA_FEAT, 32'h0000_0001);
        wr(OFF_LINE_FORMAT, 32'h0000_0038);
        rxc(8'h11, 0, 1, 0, 0);
        rxc(8'h42, 1, 0, 1, 1);
        chk("irq address", irq, 1);
        rd("status address", OFF_INT_STATUS, 32'h0000_0004);
        rd("line status perr", OFF_LINE_STATUS, 32'h0000_0004);
        wr(OFF_INT_CLEAR, 32'h0000_0004);
        rd("rx ctrl kept", OFF_RX_CTRL, 0);
        wr(OFF_RX_CTRL, 32'h0000_0001);
        rd("rx ctrl set", OFF_RX_CTRL, 1);
        rxc(8'h77, 0, 0, 1, 0);
        rxc(8'h43, 1, 0, 1, 1);
        wr(OFF_RX_CTRL, 32'h0000_0000);
        rxc(8'h78, 0, 0, 0, 0);
        wr(OFF_SOFT_OFF2, 32'h0000_005A);
        wr(OFF_ENH_FEAT, 32'h0000_0020);
        wr(OFF_INT_CLEAR, 32'h0000_0004);
        rxc(8'h5A, 0, 0, 0, 0);
        rxc(8'h33, 1, 0, 0, 0);
        rd("status none", OFF_INT_STATUS, 0);
        rxc(8'h5A, 1, 0, 1, 1);
        rd("rx ctrl auto set", OFF_RX_CTRL, 1);
        rd("status match", OFF_INT_STATUS, 32'h0000_0004);
        chk("irq match", irq, 1);
        rxc(8'h21, 0, 0, 1, 0);
        rxc(8'h5A, 1, 0, 1, 1);
        rxc(8'h34, 1, 0, 0, 0);
        rd("rx ctrl auto clr", OFF_RX_CTRL, 0);
        rxc(8'h22, 0, 0, 0, 0);
        tick(5);
        summarize;
    end
endmodule // tb_rs485_direction_and_address_control
`default_nettype wire
